/* dcs_dac_ctrl.sv */
// Serial register interface, clear/load/reset control and output-state decode of the DAC.
`timescale 1ns/100ps
module dcs_dac_ctrl #(
	parameter int CODE_BITS = 18
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic                   ce,
	input  wire dcs_pkg::dcs_pins_t     pinsIn,
	output logic                        sdoOut,
	output logic                        sdoOe,
	output logic [CODE_BITS-1:0]        dacCode,
	output logic [CODE_BITS-1:0]        levelCode,
	output dcs_pkg::dcs_ctrl_t          ctrlOut,
	output dcs_pkg::dcs_outstate_t      outState
);
	import dcs_pkg::*;

	if (CODE_BITS != CODE_W) begin : gChk
		$error("dcs_dac_ctrl supports only an 18-bit code");
	end

	dcs_pins_t                pinsNow;
	dcs_pins_t                pinsPrev_ff;
	logic [FRAME_BITS-1:0]    shift_ff;
	logic [4:0]               bitCnt_ff;
	logic [FRAME_BITS-1:0]    readShift_ff;
	logic [CODE_BITS-1:0]     inputReg_ff;
	logic [CODE_BITS-1:0]     dacReg_ff;
	logic [CODE_BITS-1:0]     level_ff;
	logic [CODE_BITS-1:0]     clearCode_ff;
	dcs_ctrl_t                ctrl_ff;
	dcs_outstate_t            outState_ff;
	logic                     sdo_ff;

	dcs_frame_t               frame;
	logic                     sclkRise;
	logic                     sclkFall;
	logic                     frameOpen;
	logic                     frameStart;
	logic                     frameEnd;
	logic                     frameOk;
	logic                     wrFrame;
	logic                     rdFrame;
	logic [CODE_BITS-1:0]     frameCode;
	logic                     wrDac;
	logic                     wrCtrl;
	logic                     wrClear;
	logic                     wrSoft;
	logic                     clearPinFall;
	logic                     loadPinFall;
	logic                     resetPinFall;
	logic                     softLoad;
	logic                     softClear;
	logic                     softReset;
	logic                     clearEvent;
	logic                     loadEvent;
	logic [CODE_BITS-1:0]     pendingCode;
	logic [CODE_BITS-1:0]     nxt_dacReg;
	logic                     nxt_dacUpdate;
	logic [FRAME_BITS-1:0]    readWord;
	logic [PAYLOAD_W-1:0]     readPayload;
	dcs_ctrl_t                ctrlDefault;

	// Offset binary passes straight through; twos complement flips the sign bit.
	function automatic logic [CODE_BITS-1:0] toLevel(
		input logic [CODE_BITS-1:0] code,
		input logic                 offsetBinary
	);
		logic [CODE_BITS-1:0] res;
		res = code;
		if (!offsetBinary) begin
			res[CODE_BITS-1] = ~code[CODE_BITS-1];
		end
		return res;
	endfunction : toLevel

	// Every pin from the host crosses into ref_clk through the agreement filter.
	dcs_pin_sync #(
		.WIDTH   (6),
		.RST_VAL (PINS_IDLE)
	) uPinSync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.ce      (ce),
		.pinIn   (pinsIn),
		.pinOut  (pinsNow)
	);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pinsPrev_ff <= PINS_IDLE;
		end else if (ce) begin
			pinsPrev_ff <= pinsNow;
		end
	end

	assign sclkRise     = ~pinsPrev_ff.sclk & pinsNow.sclk;
	assign sclkFall     = pinsPrev_ff.sclk & ~pinsNow.sclk;
	assign frameOpen    = ~pinsNow.syncN;
	assign frameStart   = pinsPrev_ff.syncN & ~pinsNow.syncN;
	assign frameEnd     = ~pinsPrev_ff.syncN & pinsNow.syncN;
	assign clearPinFall = pinsPrev_ff.clearToCodeRequestN & ~pinsNow.clearToCodeRequestN;
	assign loadPinFall  = pinsPrev_ff.loadOutputStrobeN & ~pinsNow.loadOutputStrobeN;
	assign resetPinFall = pinsPrev_ff.resetPinN & ~pinsNow.resetPinN;

	// Input bits are taken on falling link-clock edges while the frame is open.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shift_ff <= '0;
		end else if (ce && frameOpen && sclkFall) begin
			shift_ff <= {shift_ff[FRAME_BITS-2:0], pinsNow.sdin};
		end
	end

	// The counter sticks at the over value so a long frame is dropped, not wrapped.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bitCnt_ff <= 5'h00;
		end else if (ce) begin
			if (frameStart) begin
				bitCnt_ff <= 5'h00;
			end else if (frameOpen && sclkFall && bitCnt_ff != BIT_CNT_OVER) begin
				bitCnt_ff <= bitCnt_ff + 5'h01;
			end
		end
	end

	assign frame     = dcs_frame_t'(shift_ff);
	assign frameOk   = frameEnd && (bitCnt_ff == BIT_CNT_FULL);
	assign wrFrame   = frameOk && !frame.rw;
	assign rdFrame   = frameOk && frame.rw;
	assign frameCode = frame.payload[CODE_LSB_POS +: CODE_BITS];
	assign wrDac     = wrFrame && (frame.addr == ADDR_DAC);
	assign wrCtrl    = wrFrame && (frame.addr == ADDR_CTRL);
	assign wrClear   = wrFrame && (frame.addr == ADDR_CLEAR);
	assign wrSoft    = wrFrame && (frame.addr == ADDR_SOFT);

	// A strobe bit behaves as a low pulse on the matching pin, but load is ignored while clear is low and clear while load is low.
	assign softLoad  = wrSoft && frame.payload[SOFT_LOAD_POS]
		&& pinsNow.clearToCodeRequestN;
	assign softClear = wrSoft && frame.payload[SOFT_CLEAR_POS]
		&& pinsNow.loadOutputStrobeN;
	assign softReset = (wrSoft && frame.payload[SOFT_RESET_POS])
		|| resetPinFall;

	assign clearEvent = clearPinFall || softClear;
	assign loadEvent  = loadPinFall || softLoad
		|| (wrDac && !pinsNow.loadOutputStrobeN);

	// A DAC write with the load pin already low goes out at once, so it bypasses the input register.
	assign pendingCode = wrDac ? frameCode : inputReg_ff;

	// Clear takes priority over a load landing in the same cycle.
	always_comb begin
		nxt_dacReg    = dacReg_ff;
		nxt_dacUpdate = 1'b0;
		if (clearEvent) begin
			nxt_dacReg    = clearCode_ff;
			nxt_dacUpdate = 1'b1;
		end else if (loadEvent) begin
			nxt_dacReg    = pendingCode;
			nxt_dacUpdate = 1'b1;
		end
	end

	assign ctrlDefault = '{
		linComp:                LIN_RST,
		sdoDisable:             SDOD_RST,
		codingSelect:           CODING_RST,
		outputTristateBit:      TRI_RST,
		groundClampBit:         CLAMP_RST,
		feedbackResistorSelect: FBRES_RST
	};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			inputReg_ff <= DAC_RST;
		end else if (ce) begin
			if (softReset) begin
				inputReg_ff <= DAC_RST;
			end else if (wrDac) begin
				inputReg_ff <= frameCode;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dacReg_ff <= DAC_RST;
		end else if (ce) begin
			if (softReset) begin
				dacReg_ff <= DAC_RST;
			end else begin
				dacReg_ff <= nxt_dacReg;
			end
		end
	end

	// The level is fixed at load time, so reset leaves it at the negative reference.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			level_ff <= LEVEL_RST;
		end else if (ce) begin
			if (softReset) begin
				level_ff <= LEVEL_RST;
			end else if (nxt_dacUpdate) begin
				level_ff <= toLevel(nxt_dacReg, ctrl_ff.codingSelect);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			clearCode_ff <= CLEAR_RST;
		end else if (ce) begin
			if (softReset) begin
				clearCode_ff <= CLEAR_RST;
			end else if (wrClear) begin
				clearCode_ff <= frameCode;
			end
		end
	end

	// Control bits hold their power-on values until the host rewrites them.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_ff <= '{
				linComp:                LIN_RST,
				sdoDisable:             SDOD_RST,
				codingSelect:           CODING_RST,
				outputTristateBit:      TRI_RST,
				groundClampBit:         CLAMP_RST,
				feedbackResistorSelect: FBRES_RST
			};
		end else if (ce) begin
			if (softReset) begin
				ctrl_ff <= ctrlDefault;
			end else if (wrCtrl) begin
				ctrl_ff.feedbackResistorSelect <= frame.payload[CTRL_FBRES_POS];
				ctrl_ff.groundClampBit         <= frame.payload[CTRL_CLAMP_POS];
				ctrl_ff.outputTristateBit      <= frame.payload[CTRL_TRI_POS];
				ctrl_ff.codingSelect           <= frame.payload[CTRL_CODE_POS];
				ctrl_ff.sdoDisable             <= frame.payload[CTRL_SDOD_POS];
				ctrl_ff.linComp                <= frame.payload[CTRL_LIN_LSB +: 4];
			end
		end
	end

	// Clamp overrides tristate so a stray tristate write cannot float a clamped output.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			outState_ff <= '{normal: 1'b0, tristate: 1'b0, clamp: 1'b1};
		end else if (ce) begin
			outState_ff.clamp    <= ctrl_ff.groundClampBit;
			outState_ff.tristate <= ~ctrl_ff.groundClampBit
				& ctrl_ff.outputTristateBit;
			outState_ff.normal   <= ~ctrl_ff.groundClampBit
				& ~ctrl_ff.outputTristateBit;
		end
	end

	// The strobe register is write-only and reads back as zero.
	always_comb begin
		readPayload = '0;
		case (frame.addr)
			ADDR_DAC: begin
				readPayload[CODE_LSB_POS +: CODE_BITS] = dacReg_ff;
			end
			ADDR_CTRL: begin
				readPayload[CTRL_FBRES_POS]    = ctrl_ff.feedbackResistorSelect;
				readPayload[CTRL_CLAMP_POS]    = ctrl_ff.groundClampBit;
				readPayload[CTRL_TRI_POS]      = ctrl_ff.outputTristateBit;
				readPayload[CTRL_CODE_POS]     = ctrl_ff.codingSelect;
				readPayload[CTRL_SDOD_POS]     = ctrl_ff.sdoDisable;
				readPayload[CTRL_LIN_LSB +: 4] = ctrl_ff.linComp;
			end
			ADDR_CLEAR: begin
				readPayload[CODE_LSB_POS +: CODE_BITS] = clearCode_ff;
			end
			default: begin
				readPayload = '0;
			end
		endcase
	end

	assign readWord = {1'b1, frame.addr, readPayload};

	// A read frame loads the answer, which leaves on rising edges of the next frame.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			readShift_ff <= '0;
		end else if (ce) begin
			if (rdFrame) begin
				readShift_ff <= readWord;
			end else if (frameEnd) begin
				readShift_ff <= '0;
			end else if (frameOpen && sclkRise) begin
				readShift_ff <= {readShift_ff[FRAME_BITS-2:0], 1'b0};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sdo_ff <= 1'b0;
		end else if (ce) begin
			sdo_ff <= readShift_ff[FRAME_BITS-1];
		end
	end

	// The enable trails the frame-select pin by the filter delay, so the host must wait for it.
	assign sdoOut    = sdo_ff;
	assign sdoOe     = frameOpen & ~ctrl_ff.sdoDisable;
	assign dacCode   = dacReg_ff;
	assign levelCode = level_ff;
	assign ctrlOut   = ctrl_ff;
	assign outState  = outState_ff;

endmodule : dcs_dac_ctrl

/* dcs_pkg.sv */
// Shared constants, field layouts and carrier types for the DAC control block.
package dcs_pkg;

	// Serial frame layout.
	localparam int          FRAME_BITS     = 24;
	localparam int          ADDR_W         = 3;
	localparam int          PAYLOAD_W      = 20;
	localparam int          CODE_W         = 18;
	localparam int          CODE_LSB_POS   = 2;
	localparam logic [4:0]  BIT_CNT_FULL   = 5'h18;
	localparam logic [4:0]  BIT_CNT_OVER   = 5'h19;

	// Register address field values.
	localparam logic [2:0]  ADDR_NOP       = 3'h0;
	localparam logic [2:0]  ADDR_DAC       = 3'h1;
	localparam logic [2:0]  ADDR_CTRL      = 3'h2;
	localparam logic [2:0]  ADDR_CLEAR     = 3'h3;
	localparam logic [2:0]  ADDR_SOFT      = 3'h4;

	// Software strobe register bit positions.
	localparam int          SOFT_LOAD_POS  = 0;
	localparam int          SOFT_CLEAR_POS = 1;
	localparam int          SOFT_RESET_POS = 2;

	// Control register bit positions.
	localparam int          CTRL_FBRES_POS = 1;
	localparam int          CTRL_CLAMP_POS = 2;
	localparam int          CTRL_TRI_POS   = 3;
	localparam int          CTRL_CODE_POS  = 4;
	localparam int          CTRL_SDOD_POS  = 5;
	localparam int          CTRL_LIN_LSB   = 6;

	// Reset values.
	localparam logic [17:0] CLEAR_RST      = 18'h00000;
	localparam logic [17:0] DAC_RST        = 18'h00000;
	localparam logic [17:0] LEVEL_RST      = 18'h00000;
	localparam logic        FBRES_RST      = 1'h1;
	localparam logic        CLAMP_RST      = 1'h1;
	localparam logic        TRI_RST        = 1'h1;
	localparam logic        CODING_RST     = 1'h0;
	localparam logic        SDOD_RST       = 1'h0;
	localparam logic [3:0]  LIN_RST        = 4'h0;
	localparam logic [3:0]  LIN_SPAN20     = 4'hC;
	localparam logic [5:0]  PINS_IDLE      = 6'h3C;

	typedef struct packed {
		logic                 rw;
		logic [ADDR_W-1:0]    addr;
		logic [PAYLOAD_W-1:0] payload;
	} dcs_frame_t;

	typedef struct packed {
		logic [3:0] linComp;
		logic       sdoDisable;
		logic       codingSelect;
		logic       outputTristateBit;
		logic       groundClampBit;
		logic       feedbackResistorSelect;
	} dcs_ctrl_t;

	typedef struct packed {
		logic normal;
		logic tristate;
		logic clamp;
	} dcs_outstate_t;

	// Order matches PINS_IDLE: sclk idles low, the strobes idle high.
	typedef struct packed {
		logic syncN;
		logic clearToCodeRequestN;
		logic loadOutputStrobeN;
		logic resetPinN;
		logic sclk;
		logic sdin;
	} dcs_pins_t;

endpackage : dcs_pkg

/* dcs_pin_sync.sv */
// Three-stage pin synchroniser whose output moves only when stages two and three agree.
`timescale 1ns/100ps
module dcs_pin_sync #(
	parameter int               WIDTH   = 6,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);
	import dcs_pkg::*;

	if (WIDTH < 1) begin : gChk
		$error("dcs_pin_sync needs at least one bit");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : gBit
		logic stage1_ff;
		logic stage2_ff;
		logic stage3_ff;
		logic stable_ff;

		// Stage one feeds stage two only; the agreement check looks at two and three.
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				stage1_ff <= RST_VAL[i];
				stage2_ff <= RST_VAL[i];
				stage3_ff <= RST_VAL[i];
			end else if (ce) begin
				stage1_ff <= pinIn[i];
				stage2_ff <= stage1_ff;
				stage3_ff <= stage2_ff;
			end
		end

		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				stable_ff <= RST_VAL[i];
			end else if (ce && (stage2_ff == stage3_ff)) begin
				stable_ff <= stage3_ff;
			end
		end

		assign pinOut[i] = stable_ff;
	end

endmodule : dcs_pin_sync

/* dcs_dac_checker.sv */
// Concurrent checks on the ports of the DAC control block.
`timescale 1ns/100ps
module dcs_dac_checker #(
	parameter int CODE_BITS = 18
) (
	input wire logic                   ref_clk,
	input wire logic                   rstn,
	input wire logic                   ce,
	input wire dcs_pkg::dcs_pins_t     pinsIn,
	input wire logic                   sdoOut,
	input wire logic                   sdoOe,
	input wire logic [CODE_BITS-1:0]   dacCode,
	input wire logic [CODE_BITS-1:0]   levelCode,
	input wire dcs_pkg::dcs_ctrl_t     ctrlOut,
	input wire dcs_pkg::dcs_outstate_t outState
);
	import dcs_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Counts cycles with the clear pin low and the load pin high; the filter delay is skipped.
	logic [3:0] clearLowCnt_ff;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			clearLowCnt_ff <= 4'h0;
		end else if (pinsIn.clearToCodeRequestN || !pinsIn.loadOutputStrobeN) begin
			clearLowCnt_ff <= 4'h0;
		end else if (clearLowCnt_ff != 4'hF) begin
			clearLowCnt_ff <= clearLowCnt_ff + 4'h1;
		end
	end

	AST_ONE_STATE: assert property ($onehot(outState))
		else $error("output state is not one-hot");
	AST_CLAMP_WINS: assert property (ctrlOut.groundClampBit |=> outState.clamp)
		else $error("clamp bit set but output not clamped");
	AST_TRI_ONLY: assert property ((ctrlOut.outputTristateBit && !ctrlOut.groundClampBit)
		|=> outState.tristate) else $error("tristate bit alone but output not tristate");
	AST_NORMAL: assert property (!(ctrlOut.outputTristateBit || ctrlOut.groundClampBit)
		|=> outState.normal) else $error("both bits clear but output not normal");
	AST_POWER_ON: assert property ($rose(rstn) |-> ctrlOut == 9'h007 && outState.clamp
		&& dacCode == '0) else $error("wrong state after reset release");
	AST_LIN_DEFAULT: assert property ($rose(rstn) |-> ctrlOut.linComp == LIN_RST)
		else $error("linearity field not zero after reset");
	AST_FRAME_ONLY: assert property ((pinsIn.syncN == 1'b0)[*8] |-> $stable(ctrlOut))
		else $error("control changed inside an open frame");
	AST_CLEAR_HOLD: assert property (clearLowCnt_ff >= 4'hA |-> $stable(dacCode))
		else $error("DAC register moved while clear pin held low");
	AST_SDO_IDLE: assert property (pinsIn.syncN[*6] |-> !sdoOe)
		else $error("data out driven outside a frame");

	cover property (outState.normal);
	cover property (outState.tristate);
	cover property ($fell(pinsIn.clearToCodeRequestN));
endmodule : dcs_dac_checker

bind dcs_dac_ctrl dcs_dac_checker #(.CODE_BITS(CODE_BITS)) i_chk (
	.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .pinsIn(pinsIn), .sdoOut(sdoOut),
	.sdoOe(sdoOe), .dacCode(dacCode), .levelCode(levelCode), .ctrlOut(ctrlOut),
	.outState(outState)
);

/* dcs_host_model.sv */
// Serial host model driving the frame and strobe pins of the DAC control block.
`timescale 1ns/100ps
module dcs_host_model (
	input  wire logic          sdoOut,
	input  wire logic          sdoOe,
	output dcs_pkg::dcs_pins_t pins
);
	import dcs_pkg::*;
	initial pins = PINS_IDLE;

	// Sends the top nBits of word MSB first and gathers the answer bits before each rising clock.
	task automatic xfer(input logic [23:0] word, input int nBits, output logic [23:0] rd);
		rd = 24'h000000;
		pins.syncN <= 1'b0;
		#62.5;
		for (int i = 0; i < nBits; i++) begin
			rd = {rd[22:0], sdoOe ? sdoOut : 1'bx};
			pins.sclk <= 1'b1;
			pins.sdin <= word[23-i];
			#62.5;
			pins.sclk <= 1'b0;
			#62.5;
		end
		pins.syncN <= 1'b1;
		// The line is released, so it must not keep showing the last bit.
		pins.sdin <= ~pins.sdin;
		#250;
	endtask : xfer

	task automatic drivePin(input int pos, input logic val);
		pins[pos] <= val;
		#100;
	endtask : drivePin
endmodule : dcs_host_model

/* testbench.sv */
// Self-checking testbench for the DAC control block.
`timescale 1ns/100ps
module testbench;
	import dcs_pkg::*;
	localparam int          CLEAR_PIN = 4;
	localparam int          LOAD_PIN  = 3;
	localparam int          RST_PIN   = 2;
	localparam logic [23:0] CTRL_DEF  = {15'h0000, LIN_RST, SDOD_RST, CODING_RST, TRI_RST,
		CLAMP_RST, FBRES_RST};
	localparam logic [17:0] CODE      = 18'h2ABCD;
	logic          ref_clk;
	logic          rstn;
	logic          ce;
	dcs_pins_t     pins;
	logic          sdoOut;
	logic          sdoOe;
	logic [17:0]   dacCode;
	logic [17:0]   levelCode;
	dcs_ctrl_t     ctrlOut;
	dcs_outstate_t outState;
	int            mismatches;
	int            compares;
	logic [23:0]   rd;

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	dcs_dac_ctrl #(.CODE_BITS(18)) i_dut (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .pinsIn(pins), .sdoOut(sdoOut),
		.sdoOe(sdoOe), .dacCode(dacCode), .levelCode(levelCode), .ctrlOut(ctrlOut),
		.outState(outState)
	);
	dcs_host_model i_host (.sdoOut(sdoOut), .sdoOe(sdoOe), .pins(pins));

	task automatic checkVal(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : checkVal

	task automatic wr(input logic [2:0] addr, input logic [19:0] pl);
		logic [23:0] unused;
		i_host.xfer({1'b0, addr, pl}, 24, unused);
		repeat (10) @(posedge ref_clk);
	endtask : wr

	task automatic rdReg(input logic [2:0] addr, output logic [23:0] val);
		logic [23:0] unused;
		i_host.xfer({1'b1, addr, 20'h00000}, 24, unused);
		i_host.xfer(24'h000000, 24, val);
	endtask : rdReg

	task automatic checkOut(input logic [23:0] ctrl, input logic [2:0] st, input logic [17:0] dac);
		checkVal("ctrl", ctrl, {15'h0000, ctrlOut});
		checkVal("state", {21'h000000, st}, {21'h000000, outState});
		checkVal("dac", {6'h00, dac}, {6'h00, dacCode});
	endtask : checkOut

	task automatic testPowerOn();
		checkOut(CTRL_DEF, 3'h1, DAC_RST);
		checkVal("level", 24'h000000, {6'h00, levelCode});
		wr(ADDR_DAC, {18'h15555, 2'h0});
		checkOut(CTRL_DEF, 3'h1, DAC_RST);
		$display("test power_on done");
	endtask : testPowerOn

	task automatic testConfig();
		logic [19:0] pl;
		for (int t = 3; t >= 0; t--) begin
			pl = {10'h000, 4'h0, 1'b0, 1'b1, t[1], t[0], 1'b1, 1'b0};
			wr(ADDR_CTRL, pl);
			checkOut({15'h0000, pl[9:1]}, t[0] ? 3'h1 : (t[1] ? 3'h2 : 3'h4), DAC_RST);
		end
		checkVal("level", 24'h000000, {6'h00, levelCode});
		pl = {10'h000, 4'hC, 6'h10};
		wr(ADDR_CTRL, pl);
		checkOut({15'h0000, pl[9:1]}, 3'h4, DAC_RST);
		$display("test config done");
	endtask : testConfig

	task automatic testClear();
		wr(ADDR_CLEAR, {CODE, 2'h3});
		i_host.drivePin(CLEAR_PIN, 1'b0);
		checkVal("dac", {6'h00, CODE}, {6'h00, dacCode});
		checkVal("level", {6'h00, CODE}, {6'h00, levelCode});
		i_host.drivePin(CLEAR_PIN, 1'b1);
		rdReg(ADDR_CLEAR, rd);
		checkVal("clear read", {1'b1, ADDR_CLEAR, CODE, 2'h0}, rd);
		wr(ADDR_CTRL, {10'h000, 4'hC, 6'h00});
		wr(ADDR_DAC, {18'h00001, 2'h0});
		wr(ADDR_SOFT, 20'h00001);
		checkVal("dac", 24'h000001, {6'h00, dacCode});
		checkVal("level", 24'h020001, {6'h00, levelCode});
		wr(ADDR_SOFT, 20'h00002);
		checkVal("dac", {6'h00, CODE}, {6'h00, dacCode});
		checkVal("level", {6'h00, CODE ^ 18'h20000}, {6'h00, levelCode});
		$display("test clear done");
	endtask : testClear

	task automatic testInterlock();
		wr(ADDR_DAC, {18'h01234, 2'h0});
		i_host.drivePin(CLEAR_PIN, 1'b0);
		wr(ADDR_SOFT, 20'h00001);
		checkVal("dac", {6'h00, CODE}, {6'h00, dacCode});
		i_host.drivePin(CLEAR_PIN, 1'b1);
		i_host.drivePin(LOAD_PIN, 1'b0);
		checkVal("dac", 24'h001234, {6'h00, dacCode});
		wr(ADDR_SOFT, 20'h00002);
		checkVal("dac", 24'h001234, {6'h00, dacCode});
		i_host.drivePin(LOAD_PIN, 1'b1);
		rdReg(ADDR_SOFT, rd);
		checkVal("soft read", {1'b1, ADDR_SOFT, 20'h00000}, rd);
		$display("test interlock done");
	endtask : testInterlock

	task automatic testShortFrame();
		logic [23:0] unused;
		i_host.xfer({1'b0, ADDR_CTRL, 20'h0000C}, 23, unused);
		repeat (10) @(posedge ref_clk);
		checkOut({15'h0000, 4'hC, 5'h00}, 3'h4, 18'h01234);
		$display("test short_frame done");
	endtask : testShortFrame

	task automatic testSoftReset();
		wr(ADDR_SOFT, 20'h00004);
		checkOut(CTRL_DEF, 3'h1, DAC_RST);
		checkVal("level", 24'h000000, {6'h00, levelCode});
		rdReg(ADDR_CLEAR, rd);
		checkVal("clear read", {1'b1, ADDR_CLEAR, 20'h00000}, rd);
		wr(ADDR_CTRL, {10'h000, 4'hC, 6'h00});
		i_host.drivePin(RST_PIN, 1'b0);
		i_host.drivePin(RST_PIN, 1'b1);
		checkOut(CTRL_DEF, 3'h1, DAC_RST);
		$display("test soft_reset done");
	endtask : testSoftReset

	task automatic results();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	initial begin
		mismatches = 0;
		compares = 0;
		rstn = 1'b0;
		ce = 1'b1;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge ref_clk);
		testPowerOn();
		testConfig();
		testClear();
		testInterlock();
		testShortFrame();
		testSoftReset();
		results();
	end

	// About 23 frames of 3.3 us each; the limit leaves ample margin.
	initial begin
		#500000;
		mismatches++;
		results();
	end
endmodule : testbench
